// ### src/dac_edge_ctrl.v
// DAC waveform generator, digital I/O and shared edge/pattern FIFO behind AHB-Lite
// Notes on behaviour
// - One 16-bit DAC code per 50MHz slot; the 20MHz clock gives one slot per cycle
// - Three modes: single, FIFO stream, ramp
// - Stream consumes refills or loops endlessly
// - Stream entry carries 14 output pattern bits
// - Linear ramp start to end, chained ramps
// - Ramp pattern on outputs at start/end
// - One mode only; changeover delay after switch
// - Sixteen fixed inputs, sixteen fixed outputs
// - Edge monitor samples inputs at 100MHz; the 20MHz clock gives one sample per cycle
// - Each change pushes levels plus timestamp unless the FIFO is full
// - Capture FIFO holds 511 pairs, host-readable
// - Sticky rising and falling edge flags
// - FIFO serves capture or stream, never both
// - Event input forwards a trigger request
// - CPU and processor both reach all channels
// - Boot program loads and starts processor
`timescale 1ns/100ps
`include "dac_edge_defines.vh"
module dac_edge_ctrl (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire pr_req,
  input wire pr_write,
  input wire [7:0] pr_addr,
  input wire [31:0] pr_wdata,
  output reg pr_ack,
  output reg [31:0] pr_rdata,
  input wire [15:0] din,
  output reg [15:0] dout,
  output reg [15:0] dac_code,
  output reg dac_strobe,
  input wire event_in,
  output reg trig_req,
  input wire boot_valid,
  output reg proc_load,
  output reg proc_run,
  output reg irq
);
  // ****************************************************************
  // Registers and state
  // ****************************************************************
  reg ahb_pend;
  reg ahb_wr;
  reg [7:0] ahb_addr;
  reg [7:0] ctrl;
  reg [15:0] single_val;
  reg single_pend;
  reg [31:0] mem [0:511];
  reg [8:0] wr_ptr;
  reg [8:0] rd_ptr;
  reg [9:0] count;
  reg [15:0] din_prev;
  reg [15:0] rise;
  reg [15:0] fall;
  reg [15:0] tstamp;
  reg [7:0] dac_cnt;
  reg [7:0] smp_cnt;
  reg [7:0] chg_cnt;
  reg ramp_act;
  reg signed [32:0] ramp_cur;
  reg signed [32:0] ramp_step;
  reg [15:0] ramp_left;
  reg [15:0] ramp_end;
  reg [15:0] ramp_pat;
  reg [1:0] ramp_when;
  reg [31:0] p_edges;
  reg [15:0] p_len;
  reg [17:0] p_pat;
  reg p_valid;
  reg [4:0] irq_stat;
  reg [4:0] irq_mask;
  reg event_prev;
  reg boot_seen;
  // ****************************************************************
  // Shared access path
  // ****************************************************************
  // AHB owns the register file in its data phase; the processor waits a cycle then
  wire acc = ahb_pend | (pr_req & ~pr_ack);
  wire acc_wr = ahb_pend ? ahb_wr : pr_write;
  wire [7:0] acc_addr = ahb_pend ? ahb_addr : pr_addr;
  wire [31:0] acc_wd = ahb_pend ? hwdata : pr_wdata;
  wire wr_hit = acc & acc_wr;
  wire rd_hit = acc & ~acc_wr;
  wire [1:0] mode = ctrl[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
  wire use_cap = ctrl[`CTRL_USE_CAP];
  wire fifo_empty = (count == 10'h000);
  wire fifo_full = (count == `FIFO_MAX);
  wire dac_tick = (dac_cnt == (`DAC_DIV - 1));
  wire smp_tick = (smp_cnt == (`SAMPLE_DIV - 1));
  wire slot_ok = dac_tick & (chg_cnt == 8'h00);
  wire [31:0] chg_load = `CHANGE_CYC;
  wire [31:0] head = mem[rd_ptr];
  wire [15:0] din_change = din ^ din_prev;

  // Signed per-slot increment in 16.16 fixed point
  function signed [32:0] ramp_step_of;
    input [15:0] s;
    input [15:0] e;
    input [15:0] len;
    reg signed [32:0] delta;
    begin
      delta = $signed({1'b0, e, 16'h0000}) - $signed({1'b0, s, 16'h0000});
      ramp_step_of = delta / $signed({17'h00000, len});
    end
  endfunction

  // ****************************************************************
  // FIFO traffic decode
  // ****************************************************************
  // Capture and streaming are exclusive through use_cap, so pushes never collide
  wire cap_push = smp_tick & ctrl[`CTRL_EDGE_EN] & use_cap & (|din_change)
                  & ~fifo_full;
  wire cap_drop = smp_tick & ctrl[`CTRL_EDGE_EN] & use_cap & (|din_change)
                  & fifo_full;
  wire str_pop = slot_ok & (mode == `MODE_FIFO) & ctrl[`CTRL_RUN] & ~use_cap
                 & ~fifo_empty;
  wire str_under = slot_ok & (mode == `MODE_FIFO) & ctrl[`CTRL_RUN] & ~use_cap
                   & fifo_empty;
  // Host refills are refused while the loop recirculates, else an entry could be lost
  wire host_push = wr_hit & (acc_addr == `OFS_FIFO_WR) & ~use_cap & ~fifo_full
                   & ~(ctrl[`CTRL_LOOP] & ctrl[`CTRL_RUN]);
  wire loop_push = str_pop & ctrl[`CTRL_LOOP];
  wire cap_pop = rd_hit & (acc_addr == `OFS_CAP_RD) & use_cap & ~fifo_empty;
  wire push = cap_push | host_push | loop_push;
  wire pop = str_pop | cap_pop;
  wire [31:0] push_data = cap_push ? {tstamp, din} : (loop_push ? head : acc_wd);
  wire new_ctrl = wr_hit & (acc_addr == `OFS_CTRL);
  wire fifo_clr = new_ctrl & (acc_wd[`CTRL_CLEAR] | (acc_wd[`CTRL_USE_CAP] != use_cap));

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  reg [31:0] rd_val;
  always @* begin
    case (acc_addr)
      `OFS_CTRL: rd_val = {24'h000000, ctrl};
      `OFS_DAC_VALUE: rd_val = {16'h0000, dac_code};
      `OFS_CAP_RD: rd_val = (use_cap & ~fifo_empty) ? head : 32'h00000000;
      `OFS_STATUS: rd_val = {13'h0000, count, 2'h0, p_valid, ramp_act, (chg_cnt != 8'h00),
                             mode, fifo_full, fifo_empty};
      `OFS_EDGE: rd_val = {fall, rise};
      `OFS_DIN: rd_val = {16'h0000, din};
      `OFS_DOUT: rd_val = {16'h0000, dout};
      `OFS_RAMP_EDGE: rd_val = p_edges;
      `OFS_RAMP_LEN: rd_val = {16'h0000, p_len};
      `OFS_RAMP_PAT: rd_val = {14'h0000, p_pat};
      `OFS_IRQ_STAT: rd_val = {27'h0000000, irq_stat};
      `OFS_IRQ_MASK: rd_val = {27'h0000000, irq_mask};
      default: rd_val = 32'h00000000;
    endcase
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // One wait state so read data comes from a flip-flop with pops already applied
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ahb_pend <= 1'b0;
      ahb_wr <= 1'b0;
      ahb_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      pr_ack <= 1'b0;
      pr_rdata <= 32'h00000000;
    end else begin
      hresp <= 1'b0;
      if (ahb_pend) begin
        ahb_pend <= 1'b0;
        hreadyout <= 1'b1;
        hrdata <= acc_wr ? 32'h00000000 : rd_val;
      end else if (hsel & hready & htrans[1]) begin
        ahb_pend <= 1'b1;
        ahb_wr <= hwrite;
        ahb_addr <= {haddr[7:2], 2'b00};
        hreadyout <= 1'b0;
      end
      pr_ack <= ~ahb_pend & pr_req & ~pr_ack;
      if (~ahb_pend & pr_req & ~pr_ack) begin
        pr_rdata <= pr_write ? 32'h00000000 : rd_val;
      end
    end
  end

  // ****************************************************************
  // FIFO storage
  // ****************************************************************
  // Storage has no reset so it can map onto block memory
  always @(posedge hclk) begin
    if (push & ~fifo_clr) begin
      mem[wr_ptr] <= push_data;
    end
  end

  // Pointers and fill level of the shared FIFO
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= 9'h000;
      rd_ptr <= 9'h000;
      count <= 10'h000;
    end else if (fifo_clr) begin
      wr_ptr <= 9'h000;
      rd_ptr <= 9'h000;
      count <= 10'h000;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 9'h001;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 9'h001;
      end
      if (push & ~pop) begin
        count <= count + 10'h001;
      end else if (pop & ~push) begin
        count <= count - 10'h001;
      end
    end
  end

  // ****************************************************************
  // Rate dividers and changeover timer
  // ****************************************************************
  // A clock slower than the documented rates gives one slot every cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dac_cnt <= 8'h00;
      smp_cnt <= 8'h00;
      chg_cnt <= 8'h00;
    end else begin
      dac_cnt <= dac_tick ? 8'h00 : dac_cnt + 8'h01;
      smp_cnt <= smp_tick ? 8'h00 : smp_cnt + 8'h01;
      if (new_ctrl & (acc_wd[1:0] != mode)) begin
        chg_cnt <= chg_load[7:0];
      end else if (chg_cnt != 8'h00) begin
        chg_cnt <= chg_cnt - 8'h01;
      end
    end
  end

  // ****************************************************************
  // Control, DAC modes and digital outputs
  // ****************************************************************
  // The mode field is a single value, so at most one generator drives the DAC
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `CTRL_RESET;
      single_val <= 16'h0000;
      single_pend <= 1'b0;
      dac_code <= 16'h0000;
      dac_strobe <= 1'b0;
      dout <= 16'h0000;
      ramp_act <= 1'b0;
      ramp_cur <= 33'h000000000;
      ramp_step <= 33'h000000000;
      ramp_left <= 16'h0000;
      ramp_end <= 16'h0000;
      ramp_pat <= 16'h0000;
      ramp_when <= 2'h0;
      p_edges <= 32'h00000000;
      p_len <= 16'h0000;
      p_pat <= 18'h00000;
      p_valid <= 1'b0;
    end else begin
      dac_strobe <= 1'b0;
      if (new_ctrl) begin
        ctrl <= {acc_wd[7:6], 1'b0, acc_wd[4:0]};
        if (acc_wd[1:0] != mode) begin
          ramp_act <= 1'b0;
          p_valid <= 1'b0;
          single_pend <= 1'b0;
        end
      end
      if (wr_hit & (acc_addr == `OFS_DAC_VALUE)) begin
        single_val <= acc_wd[15:0];
        single_pend <= 1'b1;
      end
      if (wr_hit & (acc_addr == `OFS_DOUT)) begin
        dout <= acc_wd[15:0];
      end
      if (wr_hit & (acc_addr == `OFS_RAMP_EDGE)) begin
        p_edges <= acc_wd;
      end
      if (wr_hit & (acc_addr == `OFS_RAMP_PAT)) begin
        p_pat <= acc_wd[17:0];
      end
      // Length write queues the next ramp; a second one while one waits is refused
      if (wr_hit & (acc_addr == `OFS_RAMP_LEN) & ~p_valid & (acc_wd[15:0] != 16'h0000)) begin
        p_len <= acc_wd[15:0];
        p_valid <= 1'b1;
      end
      if (slot_ok & (mode == `MODE_SINGLE) & single_pend & ~new_ctrl) begin
        dac_code <= single_val;
        dac_strobe <= 1'b1;
        single_pend <= wr_hit & (acc_addr == `OFS_DAC_VALUE); // A write in this slot stays queued
      end
      if (str_pop) begin
        dac_code <= head[15:0];
        dout[13:0] <= head[29:16];
        dac_strobe <= 1'b1;
      end
      if (slot_ok & (mode == `MODE_RAMP) & ~new_ctrl) begin
        if (ramp_act) begin
          dac_strobe <= 1'b1;
          if (ramp_left == 16'h0001) begin
            dac_code <= ramp_end;
            ramp_act <= 1'b0;
            if (ramp_when[1]) begin
              dout <= ramp_pat;
            end
          end else begin
            dac_code <= ramp_cur[31:16];
            ramp_cur <= ramp_cur + ramp_step;
            ramp_left <= ramp_left - 16'h0001;
          end
        end else if (p_valid) begin
          // Chained ramp starts at the slot after its predecessor ends
          ramp_act <= 1'b1;
          p_valid <= 1'b0;
          ramp_cur <= $signed({1'b0, p_edges[15:0], 16'h0000});
          ramp_step <= ramp_step_of(p_edges[15:0], p_edges[31:16], p_len);
          ramp_left <= p_len;
          ramp_end <= p_edges[31:16];
          ramp_pat <= p_pat[15:0];
          ramp_when <= p_pat[17:16];
          if (p_pat[16]) begin
            dout <= p_pat[15:0];
          end
        end
      end
    end
  end

  // ****************************************************************
  // Edge monitor
  // ****************************************************************
  // Flags clear on read, but an edge in the same cycle survives the clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      din_prev <= 16'h0000;
      rise <= 16'h0000;
      fall <= 16'h0000;
      tstamp <= 16'h0000;
    end else if (smp_tick) begin
      din_prev <= din;
      tstamp <= ctrl[`CTRL_EDGE_EN] ? tstamp + 16'h0001 : 16'h0000;
      if (rd_hit & (acc_addr == `OFS_EDGE)) begin
        rise <= din & ~din_prev;
        fall <= ~din & din_prev;
      end else begin
        rise <= rise | (din & ~din_prev);
        fall <= fall | (~din & din_prev);
      end
    end else if (rd_hit & (acc_addr == `OFS_EDGE)) begin
      rise <= 16'h0000;
      fall <= 16'h0000;
    end
  end

  // ****************************************************************
  // Event trigger, interrupts and boot start
  // ****************************************************************
  // Set wins over the read clear so no event is lost
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_prev <= 1'b0;
      trig_req <= 1'b0;
      irq_stat <= 5'h00;
      irq_mask <= 5'h00;
      irq <= 1'b0;
      boot_seen <= 1'b0;
      proc_load <= 1'b0;
      proc_run <= 1'b0;
    end else begin
      event_prev <= event_in;
      trig_req <= ctrl[`CTRL_EVENT_EN] & event_in & ~event_prev;
      if (wr_hit & (acc_addr == `OFS_IRQ_MASK)) begin
        irq_mask <= acc_wd[4:0];
      end
      irq_stat <= ((rd_hit & (acc_addr == `OFS_IRQ_STAT)) ? 5'h00 : irq_stat)
                  | {str_under, slot_ok & ramp_act & (ramp_left == 16'h0001)
                     & (mode == `MODE_RAMP) & ~new_ctrl, cap_drop, cap_push,
                     ctrl[`CTRL_EVENT_EN] & event_in & ~event_prev};
      irq <= |(irq_stat & irq_mask);
      // Boot strap is sampled by a clocked process after reset release
      boot_seen <= 1'b1;
      proc_load <= ~boot_seen & boot_valid;
      if (proc_load) begin
        proc_run <= 1'b1;
      end
    end
  end
endmodule

// ### src/dac_edge_defines.vh
// Register offsets, field positions, reset values and timing counts of the DAC/edge block
`ifndef DAC_EDGE_DEFINES_VH
`define DAC_EDGE_DEFINES_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CTRL      8'h00
`define OFS_DAC_VALUE 8'h04
`define OFS_FIFO_WR   8'h08
`define OFS_CAP_RD    8'h0c
`define OFS_STATUS    8'h10
`define OFS_EDGE      8'h14
`define OFS_DIN       8'h18
`define OFS_DOUT      8'h1c
`define OFS_RAMP_EDGE 8'h20
`define OFS_RAMP_LEN  8'h24
`define OFS_RAMP_PAT  8'h28
`define OFS_IRQ_STAT  8'h2c
`define OFS_IRQ_MASK  8'h30
// ****************************************************************
// Control fields
// ****************************************************************
`define CTRL_MODE_LSB 0
`define CTRL_LOOP     2
`define CTRL_USE_CAP  3
`define CTRL_EDGE_EN  4
`define CTRL_CLEAR    5
`define CTRL_RUN      6
`define CTRL_EVENT_EN 7
`define CTRL_RESET    8'h00
`define MODE_IDLE     2'h0
`define MODE_SINGLE   2'h1
`define MODE_FIFO     2'h2
`define MODE_RAMP     2'h3
// ****************************************************************
// Interrupt bits
// ****************************************************************
`define IRQ_TRIG      0
`define IRQ_CAP       1
`define IRQ_DROP      2
`define IRQ_RAMP      3
`define IRQ_UNDER     4
// ****************************************************************
// Sizes and timing
// ****************************************************************
`define FIFO_MAX      10'h1ff
`define CLK_HZ        20000000
`define DAC_RATE_HZ   50000000
`define SAMPLE_HZ     100000000
`define CHANGE_NS     1000
`define DAC_DIV       (((`CLK_HZ / `DAC_RATE_HZ) < 1) ? 1 : (`CLK_HZ / `DAC_RATE_HZ))
`define SAMPLE_DIV    (((`CLK_HZ / `SAMPLE_HZ) < 1) ? 1 : (`CLK_HZ / `SAMPLE_HZ))
`define CHANGE_CYC    ((`CHANGE_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`endif

// ### test/dac_edge_props.sv
// Port-level checks for the DAC waveform and edge capture controller
`timescale 1ns/100ps
module dac_edge_props (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [1:0] htrans,
  input logic hready,
  input logic hreadyout,
  input logic hresp,
  input logic pr_req,
  input logic pr_ack,
  input logic [15:0] dac_code,
  input logic dac_strobe,
  input logic event_in,
  input logic trig_req,
  input logic proc_load,
  input logic proc_run,
  input logic irq
);
  // ****************************************************************
  // One clock domain, so one clocking and one reset for every check
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Bus side: exactly one wait cycle, always an OKAY answer
  chk_one_wait: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
    else $error("bus transfer without exactly one wait cycle");
  chk_okay_resp: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  // Processor port: acknowledge is a single pulse answering a request
  chk_ack_pulse: assert property (pr_ack |=> !pr_ack)
    else $error("processor acknowledge longer than one cycle");
  chk_ack_cause: assert property (pr_ack |-> $past(pr_req))
    else $error("processor acknowledge without request");
  // A new converter word only ever comes with its strobe
  chk_code_strobe: assert property (!dac_strobe |-> $stable(dac_code))
    else $error("converter word changed without strobe");
  // Trigger request is a pulse caused by the event input
  chk_trig_pulse: assert property (trig_req |=> !trig_req)
    else $error("trigger request longer than one cycle");
  chk_trig_cause: assert property (trig_req |-> $past(event_in))
    else $error("trigger request without event");
  // Boot: one load pulse, then the processor runs for good
  chk_load_run: assert property (proc_load |=> proc_run && !proc_load)
    else $error("processor not started after load");
  chk_run_holds: assert property (proc_run |=> proc_run)
    else $error("processor run dropped");
  chk_run_cause: assert property ($rose(proc_run) |-> $past(proc_load))
    else $error("processor run without load");
  cov_stream: cover property (dac_strobe [*4]);
  cov_trig: cover property (trig_req);
  cov_ack: cover property (pr_ack);
  cov_irq: cover property (irq);
endmodule

// ### test/proc_model.sv
// Behavioural embedded processor on the controller's access port
`timescale 1ns/100ps
module proc_model (
  input logic hclk,
  output logic pr_req,
  output logic pr_write,
  output logic [7:0] pr_addr,
  output logic [31:0] pr_wdata,
  input logic pr_ack,
  input logic [31:0] pr_rdata
);
  // Idle request at time zero
  initial begin
    pr_req = 1'b0;
    pr_write = 1'b0;
    pr_addr = 8'hff;
    pr_wdata = 32'hffffffff;
  end
  // Hold until acknowledge is sampled; afterwards scramble the lines so a
  // stale address or word can never pass for a live one
  task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
    pr_req <= 1'b1;
    pr_write <= wr;
    pr_addr <= a;
    pr_wdata <= wd;
    @(posedge hclk);
    while (pr_ack !== 1'b1) @(posedge hclk);
    rd = pr_rdata;
    pr_req <= 1'b0;
    pr_write <= ~wr;
    pr_addr <= ~a;
    pr_wdata <= ~wd;
  endtask
endmodule

// ### test/testbench.sv
// Self-checking bench for the DAC waveform and edge capture controller
`timescale 1ns/100ps
`include "dac_edge_defines.vh"
module testbench;
  logic hclk, hresetn, hsel, hwrite, event_in, boot_valid;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, rd, r1;
  logic [15:0] din;
  wire hreadyout, hresp, pr_req, pr_write, pr_ack, dac_strobe, trig_req, proc_load, proc_run, irq;
  wire [31:0] hrdata, pr_wdata, pr_rdata;
  wire [7:0] pr_addr;
  wire [15:0] dout, dac_code;
  int n_fail, total_checks, cyc, st, t0, ntrig, n0;
  logic [29:0] sq[$];
  // ****************************************************************
  // Clock, design, processor model
  // ****************************************************************
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  dac_edge_ctrl dac_edge_ctrl_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pr_req,
    .pr_write, .pr_addr, .pr_wdata, .pr_ack, .pr_rdata, .din, .dout, .dac_code, .dac_strobe,
    .event_in, .trig_req, .boot_valid, .proc_load, .proc_run, .irq);
  proc_model proc_model_inst (.hclk, .pr_req, .pr_write, .pr_addr, .pr_wdata, .pr_ack,
    .pr_rdata);
  // Log every converter word with its pattern bits, and count triggers
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (trig_req === 1'b1) ntrig <= ntrig + 1;
    if (dac_strobe === 1'b1) begin
      if (sq.size() == 0) st <= cyc;
      sq.push_back({dout[13:0], dac_code});
    end
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Single transfer: hold the address phase until ready, then the data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rdr(input logic [7:0] a);
    ahb(1'b0, a, 32'h0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    rdr(a);
    check(nm, rd, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge hclk);
  endtask
  function automatic logic [29:0] ent(input int i);
    return {14'h2aa5 ^ i[13:0], 16'h1000 + i[15:0]};
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Long enough for about five times the planned traffic
  initial begin
    #200000;
    n_fail++;
    $display("mismatch watchdog expected done seen timeout");
    finish_test;
  end
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    event_in = 1'b0;
    boot_valid = 1'b1;
    din = 16'h0;
    idle(16);
    hresetn <= 1'b1;
    idle(3);
    check("proc_run", proc_run, 1);
    check("dac_code", dac_code, 0);
    // Fixed outputs reached by both masters, inputs read by the processor
    wr(`OFS_DOUT, 32'h5a3c);
    check("dout", dout, 32'h5a3c);
    proc_model_inst.access(1'b1, `OFS_DOUT, 32'hc3a5, r1);
    rdc(`OFS_DOUT, 32'hc3a5, "dout_rb");
    din <= 16'h1234;
    idle(4);
    proc_model_inst.access(1'b0, `OFS_DIN, 32'h0, r1);
    check("din", r1, 32'h1234);
    $display("test io done");
    // Single value: held back until the changeover is over
    wr(`OFS_CTRL, 32'h1);
    t0 = cyc;
    sq.delete();
    wr(`OFS_DAC_VALUE, 32'hbeef);
    idle(30);
    check("single_n", sq.size(), 1);
    check("single", sq[0][15:0], 16'hbeef);
    check("change_gap", st - t0 >= 19, 1);
    $display("test single done");
    // Stream three entries, then loop two; pushes only with run off
    wr(`OFS_CTRL, 32'h2);
    idle(25);
    for (int i = 0; i < 3; i++) wr(`OFS_FIFO_WR, {2'h0, ent(i)});
    rdr(`OFS_STATUS);
    check("count", rd[18:9], 3);
    sq.delete();
    wr(`OFS_CTRL, 32'h42);
    idle(10);
    check("stream_n", sq.size(), 3);
    for (int i = 0; i < 3; i++) check("stream", sq[i], ent(i));
    wr(`OFS_CTRL, 32'h2);
    wr(`OFS_FIFO_WR, {2'h0, ent(5)});
    wr(`OFS_FIFO_WR, {2'h0, ent(6)});
    sq.delete();
    wr(`OFS_CTRL, 32'h46);
    idle(10);
    wr(`OFS_CTRL, 32'h22);
    check("loop_n", sq.size() >= 6, 1);
    for (int i = 0; i < 6; i++) check("loop", sq[i], ent(5 + i % 2));
    $display("test stream done");
    // Two chained ramps, start and end patterns
    wr(`OFS_CTRL, 32'h3);
    idle(25);
    sq.delete();
    wr(`OFS_RAMP_EDGE, 32'h0500_0100);
    wr(`OFS_RAMP_PAT, 32'h0003_a5a5);
    wr(`OFS_RAMP_LEN, 32'h10);
    wr(`OFS_RAMP_EDGE, 32'h0200_0500);
    wr(`OFS_RAMP_PAT, 32'h0002_0f0f);
    wr(`OFS_RAMP_LEN, 32'h2);
    idle(30);
    check("ramp_first", sq[0], {14'h25a5, 16'h0100});
    check("ramp_last", sq[$][15:0], 16'h0200);
    check("ramp_n", sq.size() >= 18, 1);
    check("ramp_pat", dout, 16'h0f0f);
    rdr(`OFS_IRQ_STAT);
    check("ramp_irq", rd[`IRQ_RAMP], 1);
    $display("test ramp done");
    // Edge capture: two changes five samples apart, then overflow
    wr(`OFS_CTRL, 32'h38);
    wr(`OFS_CTRL, 32'h18);
    rdr(`OFS_EDGE);
    din <= 16'h1235;
    idle(5);
    din <= 16'h1234;
    idle(3);
    rdr(`OFS_STATUS);
    check("cap_count", rd[18:9], 2);
    rdr(`OFS_CAP_RD);
    r1 = rd;
    check("levels1", rd[15:0], 16'h1235);
    rdr(`OFS_CAP_RD);
    check("levels2", rd[15:0], 16'h1234);
    check("stamp", 16'(rd[31:16] - r1[31:16]), 16'h5);
    rdc(`OFS_CAP_RD, 32'h0, "cap_empty");
    rdc(`OFS_EDGE, 32'h0001_0001, "edges");
    rdc(`OFS_EDGE, 32'h0, "edges_clr");
    wr(`OFS_FIFO_WR, 32'h1234);
    rdc(`OFS_STATUS, 32'h1, "no_mix");
    repeat (520) begin
      @(posedge hclk);
      din <= ~din;
    end
    rdr(`OFS_STATUS);
    check("full_count", rd[18:9], 10'h1ff);
    check("full_flag", rd[1], 1);
    rdr(`OFS_IRQ_STAT);
    check("drop_irq", rd[`IRQ_DROP], 1);
    $display("test capture done");
    // Event trigger with the interrupt unmasked, then masked
    wr(`OFS_CTRL, 32'h80);
    rdr(`OFS_IRQ_STAT);
    for (int m = 1; m >= 0; m--) begin
      wr(`OFS_IRQ_MASK, m);
      n0 = ntrig;
      event_in <= 1'b1;
      idle(3);
      event_in <= 1'b0;
      idle(3);
      check("trig", ntrig - n0, 1);
      check("irq", irq, m);
      rdc(`OFS_IRQ_STAT, 32'h1, "irq_stat");
    end
    idle(3);
    check("irq_clr", irq, 0);
    $display("test event done");
    // Second reset with no boot program: the processor must stay stopped
    boot_valid <= 1'b0;
    hresetn <= 1'b0;
    idle(2);
    hresetn <= 1'b1;
    idle(3);
    check("no_boot", proc_run, 0);
    $display("test boot done");
    finish_test;
  end
endmodule
bind dac_edge_ctrl dac_edge_props dac_edge_props_inst (.hclk, .hresetn, .hsel, .htrans,
  .hready, .hreadyout, .hresp, .pr_req, .pr_ack, .dac_code, .dac_strobe, .event_in,
  .trig_req, .proc_load, .proc_run, .irq);
